/* include/acpm_pkg.sv */
// Shared constants and types for the amplifier pin manager
package acpm_pkg;

  // Operating phases after reset release
  typedef enum logic [1:0] {
    ACPM_CAPTURE,
    ACPM_INIT,
    ACPM_BOOT,
    ACPM_RUN
  } acpm_state_e;

  localparam int ACPM_NSTG = 4;

  // Bit positions inside the synchronised pin vector
  localparam int ACPM_SY_PDN  = 0;
  localparam int ACPM_SY_OC   = 1;
  localparam int ACPM_SY_OL   = 5;
  localparam int ACPM_SY_UV   = 9;
  localparam int ACPM_SY_CFG  = 10;
  localparam int ACPM_SY_TOP  = 12;
  localparam int ACPM_SY_TREF = 14;
  localparam int ACPM_SY_VA   = 15;
  localparam int ACPM_SY_VB   = 16;
  localparam int ACPM_SY_TSN  = 17;
  localparam int ACPM_SY_W    = 18;

  localparam logic [1:0] ACPM_CFG_RST  = 2'h0;
  localparam logic [1:0] ACPM_QD_NONE  = 2'h0;
  localparam logic [1:0] ACPM_QD_UP    = 2'h1;
  localparam logic [1:0] ACPM_QD_DOWN  = 2'h2;

  localparam int           ACPM_CAL_W    = 16;
  localparam logic [15:0]  ACPM_CAL_ZERO = 16'h0000;
  localparam logic [15:0]  ACPM_CAL_ONE  = 16'h0001;
  localparam logic [15:0]  ACPM_CAL_MAX  = 16'hffff;

endpackage : acpm_pkg

/* logic/acpm_pin_manager.sv */
// Pin, fault and strap control of the class-D amplifier core
//
// Summary of operation
// - Power-down low stops PWM, floats every stage
// - Core logic keeps running during power-down
// - Power-down drives all four fault outputs low
// - Stage overcurrent latch; firmware or power-down clears
// - Power-down input active low, idle high
// - Stage overload or overcurrent asserts its fault
// - Supply undervoltage asserts all four faults
// - Fault outputs open-drain, only pull low
// - Capture two config straps at reset exit
// - Strap pins become outputs once init is done (boot phase)
// - Config bit0 pin drives protection status
// - Topology pins read as stage configuration
// - Multi-purpose pin role follows operating phase
// - Slave select picks SPI data pin directions
// - Running: select and data-in become encoder
// - Timing pin calibrates thermal sense to clock
// - Config bit1 pin drives supply sync output
// - Config held until reset; topology not latched
`timescale 1ns/1ps
module acpm_pin_manager
  import acpm_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  outputPowerdownN,
  input  wire logic [ACPM_NSTG-1:0]  stageOvercurrent,
  input  wire logic [ACPM_NSTG-1:0]  stageOverload,
  input  wire logic                  supplyUndervoltage,
  input  wire logic [ACPM_NSTG-1:0]  fwOcClear,
  input  wire logic [ACPM_NSTG-1:0]  pwmRequest,
  input  wire logic                  initDone,
  input  wire logic                  fwRunning,
  input  wire logic                  protStatus,
  input  wire logic                  syncSource,
  input  wire logic                  coreSck,
  input  wire logic                  coreMosi,
  input  wire logic                  coreMiso,
  input  wire logic                  tempSenseDrive,
  input  wire logic                  tempSenseLevel,
  input  wire logic                  calStart,
  input  wire logic                  stageTopologyBit0,
  input  wire logic                  stageTopologyBit1,
  input  wire logic                  volumePhaseA,
  input  wire logic                  volumePhaseBIn,
  output logic                       volumePhaseBOut,
  output logic                       volumePhaseBOeN,
  input  wire logic                  thermalReferencePinIn,
  output logic                       thermalReferencePinOut,
  output logic                       thermalReferencePinOeN,
  input  wire logic                  thermalSensePinIn,
  output logic                       thermalSensePinOut,
  output logic                       thermalSensePinOeN,
  output logic                       thermalTimingPinOut,
  output logic                       thermalTimingPinOeN,
  input  wire logic                  ampConfigBit0In,
  output logic                       ampConfigBit0Out,
  output logic                       ampConfigBit0OeN,
  input  wire logic                  ampConfigBit1In,
  output logic                       ampConfigBit1Out,
  output logic                       ampConfigBit1OeN,
  output logic [ACPM_NSTG-1:0]       stageFaultNOut,
  output logic [ACPM_NSTG-1:0]       stageFaultNOeN,
  output logic [ACPM_NSTG-1:0]       pwmDriveEn,
  output logic                       stageFloat,
  output logic                       audioOutEn,
  output logic [ACPM_NSTG-1:0]       ocLatched,
  output logic [1:0]                 ampConfig,
  output logic [1:0]                 stageTopology,
  output acpm_state_e                opState,
  output logic                       spiMasterMode,
  output logic                       spiSlaveSelN,
  output logic                       pinMosi,
  output logic                       pinMiso,
  output logic                       thermalRefLevel,
  output logic                       volStepUp,
  output logic                       volStepDown,
  output logic [ACPM_CAL_W-1:0]      calCycles,
  output logic                       calDone
);

  function automatic logic spiPhase(input acpm_state_e s);
    spiPhase = (s == ACPM_INIT) || (s == ACPM_BOOT);
  endfunction : spiPhase

  function automatic logic fwActive(input acpm_state_e s);
    fwActive = (s == ACPM_BOOT) || (s == ACPM_RUN);
  endfunction : fwActive

  // Gray-sequence step of the two encoder phases
  function automatic logic [1:0] quadDir(input logic [1:0] p, input logic [1:0] c);
    logic [1:0] r;
    r = ACPM_QD_NONE;
    case ({p, c})
      4'h1, 4'h7, 4'he, 4'h8: r = ACPM_QD_UP;
      4'h2, 4'hb, 4'hd, 4'h4: r = ACPM_QD_DOWN;
      default:                r = ACPM_QD_NONE;
    endcase
    quadDir = r;
  endfunction : quadDir

  logic [ACPM_SY_W-1:0]   syncD;
  logic [ACPM_SY_W-1:0]   syncQ;
  logic                   pdnS;
  logic                   pdAct;
  logic                   uvS;
  logic [ACPM_NSTG-1:0]   ocS;
  logic [ACPM_NSTG-1:0]   olS;
  logic [ACPM_NSTG-1:0]   stageFault;
  acpm_state_e            state_r;
  acpm_state_e            state_nxt;
  logic [ACPM_NSTG-1:0]   ocLatch_r;
  logic [ACPM_NSTG-1:0]   faultOeN_r;
  logic [ACPM_NSTG-1:0]   pwmEn_r;
  logic                   float_r;
  logic [1:0]             ampCfg_r;
  logic [1:0]             topo_r;
  logic [1:0]             volPrev_r;
  logic                   volUp_r;
  logic                   volDn_r;
  logic                   calBusy_r;
  logic [ACPM_CAL_W-1:0]  calCnt_r;
  logic [ACPM_CAL_W-1:0]  calCycles_r;
  logic                   calDone_r;
  logic                   trefOut_r;
  logic                   trefOeN_r;
  logic                   tsnOut_r;
  logic                   tsnOeN_r;
  logic                   vbOut_r;
  logic                   vbOeN_r;
  logic                   cfg0Out_r;
  logic                   cfg0OeN_r;
  logic                   cfg1Out_r;
  logic                   cfg1OeN_r;
  logic                   spiIn_r;
  logic                   master;

  assign syncD = {thermalSensePinIn, volumePhaseBIn, volumePhaseA, thermalReferencePinIn,
                  stageTopologyBit1, stageTopologyBit0, ampConfigBit1In, ampConfigBit0In,
                  supplyUndervoltage, stageOverload, stageOvercurrent, outputPowerdownN};

  acpm_sync3 #(
    .W (ACPM_SY_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .d       (syncD),
    .q       (syncQ)
  );

  assign pdnS   = syncQ[ACPM_SY_PDN];
  assign pdAct  = ~pdnS;
  assign uvS    = syncQ[ACPM_SY_UV];
  assign ocS    = syncQ[ACPM_SY_OC +: ACPM_NSTG];
  assign olS    = syncQ[ACPM_SY_OL +: ACPM_NSTG];
  assign master = syncQ[ACPM_SY_VA];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ACPM_CAPTURE: state_nxt = ACPM_INIT;
      ACPM_INIT:    state_nxt = initDone ? ACPM_BOOT : ACPM_INIT;
      ACPM_BOOT:    state_nxt = fwRunning ? ACPM_RUN : ACPM_BOOT;
      ACPM_RUN:     state_nxt = ACPM_RUN;
      default:      state_nxt = ACPM_CAPTURE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ACPM_CAPTURE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // capture on first edge after release
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ampCfg_r <= ACPM_CFG_RST;
    end else if (state_r == ACPM_CAPTURE) begin
      ampCfg_r <= syncQ[ACPM_SY_CFG +: 2];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      topo_r <= ACPM_CFG_RST;
    end else begin
      topo_r <= syncQ[ACPM_SY_TOP +: 2];
    end
  end

  for (genvar i = 0; i < ACPM_NSTG; i++) begin : g_stage
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        ocLatch_r[i] <= 1'b0;
      end else if (pdAct) begin
        ocLatch_r[i] <= 1'b0;
      end else if (ocS[i]) begin
        ocLatch_r[i] <= 1'b1;
      end else if (fwOcClear[i]) begin
        ocLatch_r[i] <= 1'b0;
      end
    end

    assign stageFault[i] = ocLatch_r[i] | ocS[i] | olS[i] | uvS | pdAct;

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        faultOeN_r[i] <= 1'b1;
      end else begin
        faultOeN_r[i] <= ~stageFault[i];
      end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        pwmEn_r[i] <= 1'b0;
      end else begin
        pwmEn_r[i] <= pdnS & pwmRequest[i] & ~ocLatch_r[i] & (state_r == ACPM_RUN);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      float_r <= 1'b1;
    end else begin
      float_r <= pdAct;
    end
  end

  // Strap pins stay inputs until init is done and the boot phase starts
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg0Out_r <= 1'b0;
      cfg0OeN_r <= 1'b1;
      cfg1Out_r <= 1'b0;
      cfg1OeN_r <= 1'b1;
    end else begin
      cfg0OeN_r <= ~fwActive(state_nxt);
      cfg1OeN_r <= ~fwActive(state_nxt);
      cfg0Out_r <= protStatus;
      cfg1Out_r <= syncSource;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trefOut_r <= 1'b0;
      trefOeN_r <= 1'b1;
    end else begin
      trefOut_r <= coreSck;
      trefOeN_r <= ~spiPhase(state_nxt);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tsnOut_r <= 1'b0;
      tsnOeN_r <= 1'b1;
      vbOut_r  <= 1'b0;
      vbOeN_r  <= 1'b1;
    end else if (spiPhase(state_nxt)) begin
      tsnOut_r <= coreMosi;
      tsnOeN_r <= ~master;
      vbOut_r  <= coreMiso;
      vbOeN_r  <= master;
    end else if (state_nxt == ACPM_RUN) begin
      // Sense pin handed to the thermal routine
      tsnOut_r <= tempSenseLevel;
      tsnOeN_r <= ~tempSenseDrive;
      vbOut_r  <= 1'b0;
      vbOeN_r  <= 1'b1;
    end else begin
      tsnOut_r <= 1'b0;
      tsnOeN_r <= 1'b1;
      vbOut_r  <= 1'b0;
      vbOeN_r  <= 1'b1;
    end
  end

  // Incoming SPI data only meaningful in the SPI phases
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      spiIn_r <= 1'b0;
    end else begin
      spiIn_r <= spiPhase(state_r);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      volPrev_r <= 2'h0;
      volUp_r   <= 1'b0;
      volDn_r   <= 1'b0;
    end else begin
      volPrev_r <= {syncQ[ACPM_SY_VB], syncQ[ACPM_SY_VA]};
      volUp_r   <= (state_r == ACPM_RUN) &&
                   (quadDir(volPrev_r, {syncQ[ACPM_SY_VB], syncQ[ACPM_SY_VA]}) == ACPM_QD_UP);
      volDn_r   <= (state_r == ACPM_RUN) &&
                   (quadDir(volPrev_r, {syncQ[ACPM_SY_VB], syncQ[ACPM_SY_VA]}) == ACPM_QD_DOWN);
    end
  end

  // clock-count calibration of the sense charge time
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      calBusy_r   <= 1'b0;
      calCnt_r    <= ACPM_CAL_ZERO;
      calCycles_r <= ACPM_CAL_ZERO;
      calDone_r   <= 1'b0;
    end else begin
      calDone_r <= 1'b0;
      if (calBusy_r) begin
        // Saturating: a missing sensor must not hang the routine
        if (syncQ[ACPM_SY_TSN] || (calCnt_r == ACPM_CAL_MAX)) begin
          calBusy_r   <= 1'b0;
          calCycles_r <= calCnt_r;
          calDone_r   <= 1'b1;
        end else begin
          calCnt_r <= calCnt_r + ACPM_CAL_ONE;
        end
      end else if (calStart && (state_r == ACPM_RUN)) begin
        calBusy_r <= 1'b1;
        calCnt_r  <= ACPM_CAL_ZERO;
      end
    end
  end

  assign stageFaultNOut         = '0;
  assign stageFaultNOeN         = faultOeN_r;
  assign pwmDriveEn             = pwmEn_r;
  assign stageFloat             = float_r;
  assign audioOutEn             = ~float_r;
  assign ocLatched              = ocLatch_r;
  assign ampConfig              = ampCfg_r;
  assign stageTopology          = topo_r;
  assign opState                = state_r;
  assign ampConfigBit0Out       = cfg0Out_r;
  assign ampConfigBit0OeN       = cfg0OeN_r;
  assign ampConfigBit1Out       = cfg1Out_r;
  assign ampConfigBit1OeN       = cfg1OeN_r;
  assign thermalReferencePinOut = trefOut_r;
  assign thermalReferencePinOeN = trefOeN_r;
  assign thermalSensePinOut     = tsnOut_r;
  assign thermalSensePinOeN     = tsnOeN_r;
  assign volumePhaseBOut        = vbOut_r;
  assign volumePhaseBOeN        = vbOeN_r;
  assign thermalTimingPinOut    = calBusy_r;
  assign thermalTimingPinOeN    = ~calBusy_r;
  assign spiMasterMode          = master;
  assign spiSlaveSelN           = syncQ[ACPM_SY_VA];
  assign pinMosi                = spiIn_r & syncQ[ACPM_SY_TSN];
  assign pinMiso                = spiIn_r & syncQ[ACPM_SY_VB];
  assign thermalRefLevel        = syncQ[ACPM_SY_TREF];
  assign volStepUp              = volUp_r;
  assign volStepDown            = volDn_r;
  assign calCycles              = calCycles_r;
  assign calDone                = calDone_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_pd_float;
    !pdnS |=> (pwmDriveEn == '0) && stageFloat && !audioOutEn;
  endproperty
  a_pd_float: assert property (p_pd_float) else $error("power-down left a stage driven");

  property p_pd_run;
    (state_r == ACPM_INIT) && initDone && !pdnS |=> (state_r == ACPM_BOOT);
  endproperty
  a_pd_run: assert property (p_pd_run) else $error("sequencer stalled by power-down");

  property p_pd_faults;
    !pdnS |=> (stageFaultNOeN == '0);
  endproperty
  a_pd_faults: assert property (p_pd_faults) else $error("power-down missed a fault");

  property p_pd_clear;
    !pdnS ##1 !pdnS |-> (ocLatched == '0);
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("latch survived power-down");

  property p_oc_latch;
    pdnS && ocS[0] |=> ocLatched[0] && !stageFaultNOeN[0] ##1 !stageFaultNOeN[0];
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("overcurrent not latched");

  property p_uv_all;
    uvS |=> (stageFaultNOeN == '0);
  endproperty
  a_uv_all: assert property (p_uv_all) else $error("undervoltage missed a fault");

  property p_open_drain;
    stageFaultNOut == '0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("fault pin driven high");

  // Judged on the first INIT cycle: the release edge itself still shows reset values
  property p_capture;
    (state_r == ACPM_INIT) && ($past(state_r) == ACPM_CAPTURE) |->
      (ampConfig == $past(syncQ[ACPM_SY_CFG +: 2]));
  endproperty
  a_capture: assert property (p_capture) else $error("strap value not captured");

  property p_hold;
    (state_r != ACPM_CAPTURE) |=> $stable(ampConfig);
  endproperty
  a_hold: assert property (p_hold) else $error("captured config changed");

  property p_cap_quiet;
    (state_r == ACPM_CAPTURE) |-> ampConfigBit0OeN && ampConfigBit1OeN &&
      thermalReferencePinOeN && thermalSensePinOeN && volumePhaseBOeN;
  endproperty
  a_cap_quiet: assert property (p_cap_quiet) else $error("pin driven during capture");

  property p_run_status;
    (state_r == ACPM_RUN) |=> !ampConfigBit0OeN && (ampConfigBit0Out == $past(protStatus));
  endproperty
  a_run_status: assert property (p_run_status) else $error("status pin not driven");

  property p_spi_dir;
    spiPhase(state_r) && spiPhase(state_nxt) && $stable(master) |=>
      (thermalSensePinOeN == !$past(master)) && (volumePhaseBOeN == $past(master));
  endproperty
  a_spi_dir: assert property (p_spi_dir) else $error("SPI data direction wrong");

endmodule : acpm_pin_manager

/* logic/acpm_sync3.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module acpm_sync3 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] q_r;

  // No reset: straps must be settled while the core reset is still low
  always_ff @(posedge sys_clk) begin
    s1 <= d;
    s2 <= s1;
    s3 <= s2;
  end

  // A bit moves only when the second and third stage agree
  always_ff @(posedge sys_clk) begin
    q_r <= (s2 & ~(s2 ^ s3)) | (q_r & (s2 ^ s3));
  end

  assign q = q_r;

endmodule : acpm_sync3

/* tb/acpm_board_model.sv */
// Board model: strap resistors, volume encoder, thermal network
`timescale 1ns/1ps
module acpm_board_model #(
  parameter int CAL_DLY = 20
) (
  input  wire logic       sys_clk,
  input  wire logic [1:0] cfgStrap,
  input  wire logic       encUp,
  input  wire logic       encDown,
  input  wire logic       spiSel,
  input  wire logic       volumePhaseBOut,
  input  wire logic       volumePhaseBOeN,
  input  wire logic       ampConfigBit0Out,
  input  wire logic       ampConfigBit0OeN,
  input  wire logic       ampConfigBit1Out,
  input  wire logic       ampConfigBit1OeN,
  input  wire logic       thermalSensePinOut,
  input  wire logic       thermalSensePinOeN,
  input  wire logic       thermalReferencePinOut,
  input  wire logic       thermalReferencePinOeN,
  input  wire logic       thermalTimingPinOut,
  input  wire logic       thermalTimingPinOeN,
  output logic            volumePhaseA,
  output logic            volumePhaseBIn,
  output logic            ampConfigBit0In,
  output logic            ampConfigBit1In,
  output logic            thermalSensePinIn,
  output logic            thermalReferencePinIn
);
  logic [1:0]  encIdx_r = 2'h2;
  logic [15:0] chg_r    = 16'h0;
  // One Gray step per request
  always @(posedge sys_clk) begin
    if (encUp) encIdx_r <= encIdx_r + 2'h1;
    else if (encDown) encIdx_r <= encIdx_r - 2'h1;
  end
  // Sense node charges only while timing pin is high
  always @(posedge sys_clk) begin
    if (!thermalTimingPinOeN && thermalTimingPinOut) begin
      if (chg_r < CAL_DLY) chg_r <= chg_r + 16'h1;
    end else chg_r <= 16'h0;
  end
  // Driven pin wins, else resistor level
  assign ampConfigBit0In = ampConfigBit0OeN ? cfgStrap[0] : ampConfigBit0Out;
  assign ampConfigBit1In = ampConfigBit1OeN ? cfgStrap[1] : ampConfigBit1Out;
  // Host pulls select low, else encoder A
  assign volumePhaseA = spiSel ? 1'b0 : encIdx_r[1] ^ encIdx_r[0];
  assign volumePhaseBIn = volumePhaseBOeN ? encIdx_r[1] : volumePhaseBOut;
  assign thermalSensePinIn = thermalSensePinOeN ? (chg_r == CAL_DLY) : thermalSensePinOut;
  // Reference resistor pulls the idle pin low
  assign thermalReferencePinIn = thermalReferencePinOeN ? 1'b0 : thermalReferencePinOut;
endmodule : acpm_board_model

/* tb/acpm_pin_manager_tb.sv */
// Self-checking bench for the amplifier pin manager
`timescale 1ns/1ps
module acpm_pin_manager_tb;
  import acpm_pkg::*;
  localparam int CAL_DLY = 20;
  typedef struct packed {
    logic pd; logic [3:0] oc; logic [3:0] ol; logic uv;
    logic [3:0] flt; logic [3:0] pwm; logic pc; logic [3:0] ocl;
  } acpm_row_s;
  logic       sys_clk = 1'b0, rstn = 1'b0, outputPowerdownN = 1'b1, supplyUndervoltage = 1'b0;
  logic [3:0] stageOvercurrent = 4'h0, stageOverload = 4'h0, fwOcClear = 4'h0;
  logic [3:0] pwmRequest = 4'hf;
  logic       initDone = 1'b0, fwRunning = 1'b0, protStatus = 1'b1, syncSource = 1'b0;
  logic       coreSck = 1'b0, coreMosi = 1'b1, coreMiso = 1'b1, tempSenseDrive = 1'b0;
  logic       tempSenseLevel = 1'b0, calStart = 1'b0, encUp = 1'b0, encDown = 1'b0;
  logic       spiSel = 1'b0, stageTopologyBit0 = 1'b0, stageTopologyBit1 = 1'b1;
  logic [1:0] cfgStrap = 2'h2;
  logic       volumePhaseA, volumePhaseBIn, volumePhaseBOut, volumePhaseBOeN;
  logic       thermalReferencePinIn, thermalReferencePinOut, thermalReferencePinOeN;
  logic       thermalSensePinIn, thermalSensePinOut, thermalSensePinOeN;
  logic       thermalTimingPinOut, thermalTimingPinOeN, ampConfigBit0In, ampConfigBit0Out;
  logic       ampConfigBit0OeN, ampConfigBit1In, ampConfigBit1Out, ampConfigBit1OeN;
  logic [3:0] stageFaultNOut, stageFaultNOeN, pwmDriveEn, ocLatched;
  logic       stageFloat, audioOutEn, spiMasterMode, volStepUp, volStepDown, calDone;
  logic       spiSlaveSelN, pinMosi, pinMiso, thermalRefLevel;
  logic [1:0] ampConfig, stageTopology;
  logic [15:0] calCycles;
  acpm_state_e opState;
  int         n_fail = 0, n_checks = 0, nUp = 0, nDn = 0, nUp0, nDn0, k;
  acpm_row_s  rows [9] = '{
    '{1'b1, 4'h0, 4'h0, 1'b0, 4'hf, 4'hf, 1'b1, 4'h0},
    '{1'b0, 4'h0, 4'h0, 1'b0, 4'h0, 4'h0, 1'b1, 4'h0},
    '{1'b1, 4'h0, 4'h2, 1'b0, 4'hd, 4'h0, 1'b0, 4'h0},
    '{1'b1, 4'h0, 4'h0, 1'b1, 4'h0, 4'h0, 1'b0, 4'h0},
    '{1'b0, 4'h0, 4'h0, 1'b1, 4'h0, 4'h0, 1'b1, 4'h0},
    '{1'b1, 4'h8, 4'h0, 1'b0, 4'h7, 4'h0, 1'b0, 4'h8},
    '{1'b0, 4'h8, 4'h0, 1'b0, 4'h0, 4'h0, 1'b1, 4'h0},
    '{1'b1, 4'h0, 4'h0, 1'b0, 4'hf, 4'hf, 1'b1, 4'h0},
    '{1'b1, 4'h5, 4'ha, 1'b0, 4'h0, 4'h0, 1'b0, 4'h5}};

  acpm_pin_manager uut (
    .sys_clk, .rstn, .outputPowerdownN, .stageOvercurrent, .stageOverload,
    .supplyUndervoltage, .fwOcClear, .pwmRequest, .initDone, .fwRunning, .protStatus,
    .syncSource, .coreSck, .coreMosi, .coreMiso, .tempSenseDrive, .tempSenseLevel,
    .calStart, .stageTopologyBit0, .stageTopologyBit1, .volumePhaseA, .volumePhaseBIn,
    .volumePhaseBOut, .volumePhaseBOeN, .thermalReferencePinIn, .thermalReferencePinOut,
    .thermalReferencePinOeN, .thermalSensePinIn, .thermalSensePinOut, .thermalSensePinOeN,
    .thermalTimingPinOut, .thermalTimingPinOeN, .ampConfigBit0In, .ampConfigBit0Out,
    .ampConfigBit0OeN, .ampConfigBit1In, .ampConfigBit1Out, .ampConfigBit1OeN,
    .stageFaultNOut, .stageFaultNOeN, .pwmDriveEn, .stageFloat, .audioOutEn, .ocLatched,
    .ampConfig, .stageTopology, .opState, .spiMasterMode, .spiSlaveSelN, .pinMosi,
    .pinMiso, .thermalRefLevel, .volStepUp, .volStepDown, .calCycles, .calDone
  );
  acpm_board_model #(.CAL_DLY(CAL_DLY)) board (
    .sys_clk, .cfgStrap, .encUp, .encDown, .spiSel, .volumePhaseBOut, .volumePhaseBOeN,
    .ampConfigBit0Out, .ampConfigBit0OeN, .ampConfigBit1Out, .ampConfigBit1OeN,
    .thermalSensePinOut, .thermalSensePinOeN, .thermalReferencePinOut,
    .thermalReferencePinOeN, .thermalTimingPinOut, .thermalTimingPinOeN, .volumePhaseA,
    .volumePhaseBIn, .ampConfigBit0In, .ampConfigBit1In, .thermalSensePinIn,
    .thermalReferencePinIn
  );

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (volStepUp === 1'b1) nUp++;
    if (volStepDown === 1'b1) nDn++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // Far beyond the few hundred cycles needed
  initial begin
    #500000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    cyc(16);
    #1;
    chk({ampConfigBit0OeN, ampConfigBit1OeN, thermalReferencePinOeN}, 3'h7);
    chk({thermalSensePinOeN, volumePhaseBOeN, stageFaultNOeN}, 6'h3f);
    cyc(1);
    rstn <= 1'b1;
    cyc(1);
    #1;
    chk(ampConfig, 2'h2);
    chk(opState, ACPM_INIT);
    chk({ampConfigBit0OeN, ampConfigBit1OeN, thermalReferencePinOeN}, 3'h6);
    chk({spiMasterMode, thermalSensePinOeN, volumePhaseBOeN}, 3'h5);
    cyc(1);
    coreMosi <= 1'b0;
    coreSck <= 1'b1;
    cyc(2);
    #1;
    chk({thermalSensePinOut, spiSlaveSelN, pinMiso}, 3'h3);
    cyc(1);
    spiSel <= 1'b1;
    coreMiso <= 1'b0;
    cyc(7);
    #1;
    chk({thermalSensePinOeN, volumePhaseBOeN, volumePhaseBOut, thermalRefLevel}, 4'h9);
    cyc(1);
    spiSel <= 1'b0;
    initDone <= 1'b1;
    cyc(1);
    initDone <= 1'b0;
    #1;
    chk({opState, ampConfigBit0OeN, ampConfigBit1OeN}, {ACPM_BOOT, 2'h0});
    cyc(1);
    protStatus <= 1'b0;
    syncSource <= 1'b1;
    cyc(2);
    #1;
    chk({ampConfigBit0In, ampConfigBit1In}, 2'h1);
    cyc(1);
    fwRunning <= 1'b1;
    cyc(1);
    fwRunning <= 1'b0;
    #1;
    chk({opState, thermalReferencePinOeN, volumePhaseBOeN}, {ACPM_RUN, 2'h3});
    chk(stageTopology, 2'h2);
    cyc(1);
    stageTopologyBit0 <= 1'b1;
    stageTopologyBit1 <= 1'b0;
    cyc(6);
    #1;
    chk({stageTopology, ampConfig, thermalRefLevel}, 5'h0c);
    for (k = 0; k < 9; k++) begin
      cyc(1);
      outputPowerdownN <= rows[k].pd;
      stageOvercurrent <= rows[k].oc;
      stageOverload <= rows[k].ol;
      supplyUndervoltage <= rows[k].uv;
      cyc(7);
      #1;
      chk(stageFaultNOeN, rows[k].flt);
      chk(stageFaultNOut, 4'h0);
      chk(ocLatched, rows[k].ocl);
      if (rows[k].pc) begin
        chk(pwmDriveEn, rows[k].pwm);
        chk({stageFloat, audioOutEn}, {~rows[k].pd, rows[k].pd});
      end
    end
    cyc(1);
    stageOvercurrent <= 4'h0;
    stageOverload <= 4'h0;
    cyc(7);
    #1;
    chk(ocLatched, 4'h5);
    cyc(1);
    fwOcClear <= 4'h1;
    cyc(1);
    fwOcClear <= 4'h0;
    #1;
    chk(ocLatched, 4'h4);
    // Encoder steps taken while powered down
    cyc(1);
    outputPowerdownN <= 1'b0;
    // B pin handover from the SPI role leaves one step; count from here
    nUp0 = nUp;
    nDn0 = nDn;
    for (k = 0; k < 6; k++) begin
      cyc(1);
      encUp <= (k < 4);
      encDown <= (k >= 4);
      cyc(1);
      encUp <= 1'b0;
      encDown <= 1'b0;
      cyc(7);
    end
    #1;
    chk({4'(nUp - nUp0), 4'(nDn - nDn0)}, 8'h42);
    chk(ocLatched, 4'h0);
    cyc(1);
    outputPowerdownN <= 1'b1;
    calStart <= 1'b1;
    cyc(1);
    calStart <= 1'b0;
    #1;
    chk({thermalTimingPinOeN, thermalTimingPinOut}, 2'h1);
    k = 0;
    do begin
      cyc(1);
      #1;
      k++;
    end while (calDone !== 1'b1 && k < 200);
    chk({calDone, pinMosi}, 2'h2);
    chk(calCycles >= CAL_DLY && calCycles <= CAL_DLY + 8, 1'b1);
    cyc(1);
    tempSenseDrive <= 1'b1;
    tempSenseLevel <= 1'b1;
    cyc(2);
    #1;
    chk({thermalSensePinOeN, thermalSensePinOut}, 2'h1);
    cyc(1);
    cfgStrap <= 2'h1;
    rstn <= 1'b0;
    #1;
    chk({ampConfigBit0OeN, ampConfigBit1OeN, volumePhaseBOeN, pwmDriveEn}, 7'h70);
    cyc(8);
    rstn <= 1'b1;
    cyc(1);
    #1;
    chk({opState, ampConfig}, {ACPM_INIT, 2'h1});
    // Sequencer must still advance while powered down
    cyc(1);
    outputPowerdownN <= 1'b0;
    cyc(5);
    initDone <= 1'b1;
    cyc(1);
    initDone <= 1'b0;
    cyc(1);
    #1;
    chk({opState, stageFaultNOeN}, {ACPM_BOOT, 4'h0});
    report_and_stop();
  end
endmodule : acpm_pin_manager_tb
